// >>> common/rbcd_pkg.sv
// Package: register map, command codes, sense codes and mode-page constants
package rbcd_pkg;
	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] RBCD_CDB0 = 8'h00;
	localparam logic [7:0] RBCD_CDB1 = 8'h04;
	localparam logic [7:0] RBCD_CDB2 = 8'h08;
	localparam logic [7:0] RBCD_CTRL = 8'h0c;
	localparam logic [7:0] RBCD_RESULT = 8'h10;
	localparam logic [7:0] RBCD_DATA = 8'h14;
	localparam logic [7:0] RBCD_MODE_CUR = 8'h18;
	localparam logic [7:0] RBCD_MODE_SAVED = 8'h1c;
	localparam logic [7:0] RBCD_MODE_PARAM = 8'h20;
	localparam logic [7:0] RBCD_WB_OFFSET = 8'h24;
	localparam logic [7:0] RBCD_WB_LENGTH = 8'h28;
	localparam logic [7:0] RBCD_IRQ_STAT = 8'h2c;
	localparam logic [7:0] RBCD_IRQ_MASK = 8'h30;
	localparam logic [7:0] RBCD_STATUS = 8'h34;
	// CTRL bit positions
	localparam int RBCD_CTRL_GO = 0;
	localparam int RBCD_CTRL_RMB = 1;
	localparam int RBCD_CTRL_SAVE_OK = 2;
	localparam int RBCD_CTRL_AUTOSENSE = 3;
	localparam int RBCD_CTRL_AEN = 4;
	localparam int RBCD_CTRL_ESN = 5;
	localparam int RBCD_CTRL_WB_BLOCK = 6;
	localparam logic [31:0] RBCD_CTRL_RST = 32'h0000_0000;
	// IRQ bit positions
	localparam int RBCD_IRQ_DONE = 0;
	localparam int RBCD_IRQ_EXC = 1;
	localparam int RBCD_IRQ_CHECK = 2;
	// ----------------------------------------------------------------
	// Operation codes and field values
	// ----------------------------------------------------------------
	localparam logic [7:0] RBCD_OP_TUR = 8'h00;
	localparam logic [7:0] RBCD_OP_REQ_SENSE = 8'h03;
	localparam logic [7:0] RBCD_OP_INQUIRY = 8'h12;
	localparam logic [7:0] RBCD_OP_MODE_SEL = 8'h15;
	localparam logic [7:0] RBCD_OP_MODE_SENSE = 8'h1a;
	localparam logic [7:0] RBCD_OP_PREVENT = 8'h1e;
	localparam logic [7:0] RBCD_OP_WRITE_BUF = 8'h3b;
	localparam logic [7:0] RBCD_VPD_SERIAL = 8'h80;
	localparam logic [7:0] RBCD_VPD_DEVID = 8'h83;
	localparam logic [1:0] RBCD_PC_CUR = 2'h0;
	localparam logic [1:0] RBCD_PC_CHG = 2'h1;
	localparam logic [1:0] RBCD_PC_DEF = 2'h2;
	localparam logic [1:0] RBCD_PC_SAVED = 2'h3;
	localparam logic [2:0] RBCD_WB_SAVE = 3'h5;
	localparam logic [2:0] RBCD_WB_OFS_SAVE = 3'h7;
	// ----------------------------------------------------------------
	// Status, sense keys, additional sense codes
	// ----------------------------------------------------------------
	localparam logic [7:0] RBCD_ST_GOOD = 8'h00;
	localparam logic [7:0] RBCD_ST_CHECK = 8'h02;
	localparam logic [7:0] RBCD_SK_NONE = 8'h00;
	localparam logic [7:0] RBCD_SK_RECOVERED = 8'h01;
	localparam logic [7:0] RBCD_SK_ILLEGAL = 8'h05;
	localparam logic [7:0] RBCD_ASC_NONE = 8'h00;
	localparam logic [7:0] RBCD_ASC_BAD_OP = 8'h20;
	localparam logic [7:0] RBCD_ASC_BAD_FIELD = 8'h24;
	localparam logic [7:0] RBCD_ASC_SEQ_ERR = 8'h2c;
	localparam logic [7:0] RBCD_ASC_FAIL_PRED = 8'h5d;
	// Failure-prediction qualifier limits
	localparam logic [3:0] RBCD_QX_MIN = 4'h1;
	localparam logic [3:0] RBCD_QX_MAX = 4'h6;
	localparam logic [3:0] RBCD_QY_MAX = 4'hc;
	// ----------------------------------------------------------------
	// Mode page word
	// ----------------------------------------------------------------
	localparam logic [31:0] RBCD_MODE_DEF = 32'h0000_ff01;
	localparam logic [31:0] RBCD_MODE_CHG = 32'h0000_ff0f;

	typedef struct packed {
		logic [7:0] ascq;
		logic [7:0] asc;
		logic [7:0] key;
		logic [7:0] status;
	} rbcd_sense_t;
endpackage

// >>> hw/rbcd_top.sv
// Command interpreter for a reduced block target, reached over AXI4-Lite
// Operation
// - Inquiry for the unit serial number page 80h is answered with good status.
// - Inquiry for the device identification page 83h is answered with good status.
// - Mode select with zero parameter list length completes without error.
// - Values that cannot be changed are silently kept, no error raised.
// - Fixed medium with save-pages applies update and stores pages nonvolatile.
// - Removable medium unable to save rejects save-pages: check, 05h, 24h.
// - Current request returns last selected values; current and saved tracked apart.
// - Unavailable current or saved values report the defaults instead.
// - Defaults request returns defaults; saved request restores then reports.
// - Medium-removal prevention is implemented when the removable bit is one.
// - Request sense is implemented when autosense, notification or polling lacks.
// - Exceptions reported by readiness test only after a threshold event.
// - Delivered asynchronous notification clears exception from readiness test.
// - Exceptions carry recovered-error key and failure-prediction code 5Dh.
// - Qualifier: subsystem digit 1h..6h, cause digit 0h..Ch, rest reserved.
// - Buffer write supports download-save 101b and offset-download-save 111b.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rbcd_top import rbcd_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	// AXI4-Lite write response
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Exception events and notification, medium lock and interrupt
	input wire logic exc_event,
	input wire logic [7:0] exc_qual,
	input wire logic aen_done,
	output logic aen_req,
	output logic medium_locked,
	output logic irq
);
	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q, rd_d;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic wr_fire, rd_fire, rd_hit, wr_hit;
	assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
	assign rd_fire = s_arvalid & arready_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_hold_q <= 1'b0;
			awready_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else begin
			aw_hold_q <= (aw_hold_q & ~wr_fire) | (s_awvalid & awready_q);
			awready_q <= ~aw_hold_q & ~(s_awvalid & awready_q);
			if (s_awvalid & awready_q)
				awaddr_q <= s_awaddr;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			w_hold_q <= 1'b0;
			wready_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			w_hold_q <= (w_hold_q & ~wr_fire) | (s_wvalid & wready_q);
			wready_q <= ~w_hold_q & ~(s_wvalid & wready_q);
			if (s_wvalid & wready_q) begin
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
			end
		end
	end
	always_comb begin
		case (awaddr_q)
			RBCD_CDB0, RBCD_CDB1, RBCD_CDB2, RBCD_CTRL, RBCD_MODE_PARAM, RBCD_IRQ_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? 2'h0 : 2'h2;
		end else if (s_bready)
			bvalid_q <= 1'b0;
	end
	logic [31:0] wmask;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	// ----------------------------------------------------------------
	// Software-written registers
	// ----------------------------------------------------------------
	logic [31:0] cdb0_q, cdb1_q, cdb2_q, ctrl_q, param_q;
	logic [2:0] imask_q;
	logic go_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cdb0_q <= 32'h0000_0000;
			cdb1_q <= 32'h0000_0000;
			cdb2_q <= 32'h0000_0000;
			ctrl_q <= RBCD_CTRL_RST;
			param_q <= 32'h0000_0000;
			imask_q <= 3'h0;
			go_q <= 1'b0;
		end else begin
			go_q <= 1'b0;
			if (wr_fire) begin
				case (awaddr_q)
					RBCD_CDB0: cdb0_q <= (cdb0_q & ~wmask) | (wdata_q & wmask);
					RBCD_CDB1: cdb1_q <= (cdb1_q & ~wmask) | (wdata_q & wmask);
					RBCD_CDB2: cdb2_q <= ((cdb2_q & ~wmask) | (wdata_q & wmask)) & 32'h0000_ffff;
					RBCD_MODE_PARAM: param_q <= (param_q & ~wmask) | (wdata_q & wmask);
					RBCD_IRQ_MASK: imask_q <= (imask_q & ~wmask[2:0]) | (wdata_q[2:0] & wmask[2:0]);
					RBCD_CTRL: begin
						ctrl_q <= ((ctrl_q & ~wmask) | (wdata_q & wmask)) & 32'h0000_007e;
						go_q <= wstrb_q[0] & wdata_q[RBCD_CTRL_GO];
					end
					default: ;
				endcase
			end
		end
	end
	// ----------------------------------------------------------------
	// Descriptor decode
	// ----------------------------------------------------------------
	logic [79:0] cdb;
	logic [7:0] op;
	logic [2:0] wb_mode;
	logic [23:0] wb_ofs, wb_len;
	logic rmb, save_ok, req_sense_need;
	assign cdb = {cdb2_q[15:0], cdb1_q, cdb0_q};
	assign op = cdb[7:0];
	assign wb_mode = cdb[10:8];
	assign wb_ofs = {cdb[31:24], cdb[39:32], cdb[47:40]};
	assign wb_len = {cdb[55:48], cdb[63:56], cdb[71:64]};
	assign rmb = ctrl_q[RBCD_CTRL_RMB];
	assign save_ok = ctrl_q[RBCD_CTRL_SAVE_OK];
	assign req_sense_need = ~ctrl_q[RBCD_CTRL_AUTOSENSE] | ~ctrl_q[RBCD_CTRL_AEN] | ~ctrl_q[RBCD_CTRL_ESN];
	// ----------------------------------------------------------------
	// Command execution
	// ----------------------------------------------------------------
	rbcd_sense_t sense_q, sense_d, last_q;
	logic [31:0] data_q, data_d, cur_q, saved_q, sel_val;
	logic cur_valid_q, saved_valid_q, lock_q, exc_pend_q, exc_ev;
	logic [7:0] exc_q;
	logic [23:0] wbo_q, wbl_q;
	logic do_sel, do_save, do_restore, do_lock, do_wb;
	assign sel_val = (cur_q & ~RBCD_MODE_CHG) | (param_q & RBCD_MODE_CHG);
	always_comb begin
		sense_d = '{ascq: 8'h00, asc: RBCD_ASC_NONE, key: RBCD_SK_NONE, status: RBCD_ST_GOOD};
		data_d = 32'h0000_0000;
		do_sel = 1'b0;
		do_save = 1'b0;
		do_restore = 1'b0;
		do_lock = 1'b0;
		do_wb = 1'b0;
		case (op)
			RBCD_OP_TUR: begin
				if (exc_pend_q)
					sense_d = '{ascq: exc_q, asc: RBCD_ASC_FAIL_PRED, key: RBCD_SK_RECOVERED,
						status: RBCD_ST_CHECK};
			end
			RBCD_OP_REQ_SENSE: data_d = last_q;
			RBCD_OP_INQUIRY: begin
				if (cdb[8] && (cdb[23:16] == RBCD_VPD_SERIAL || cdb[23:16] == RBCD_VPD_DEVID))
					data_d = {24'h0, cdb[23:16]};
				else if (cdb[8])
					sense_d = '{ascq: 8'h00, asc: RBCD_ASC_BAD_FIELD, key: RBCD_SK_ILLEGAL, status: RBCD_ST_CHECK};
				else
					data_d = {31'h0, rmb};
			end
			RBCD_OP_MODE_SEL: begin
				if (cdb[8] && rmb && !save_ok)
					sense_d = '{ascq: 8'h00, asc: RBCD_ASC_BAD_FIELD, key: RBCD_SK_ILLEGAL,
						status: RBCD_ST_CHECK};
				else begin
					do_sel = cdb[39:32] != 8'h00;
					do_save = cdb[8];
				end
			end
			RBCD_OP_MODE_SENSE: begin
				case (cdb[23:22])
					RBCD_PC_CUR: data_d = cur_valid_q ? cur_q : RBCD_MODE_DEF;
					RBCD_PC_CHG: data_d = RBCD_MODE_CHG;
					RBCD_PC_DEF: data_d = RBCD_MODE_DEF;
					default: begin
						data_d = saved_valid_q ? saved_q : RBCD_MODE_DEF;
						do_restore = ~saved_valid_q;
					end
				endcase
			end
			RBCD_OP_PREVENT: begin
				if (rmb)
					do_lock = 1'b1;
				else
					sense_d = '{ascq: 8'h00, asc: RBCD_ASC_BAD_OP, key: RBCD_SK_ILLEGAL, status: RBCD_ST_CHECK};
			end
			RBCD_OP_WRITE_BUF: begin
				if (wb_mode != RBCD_WB_SAVE && wb_mode != RBCD_WB_OFS_SAVE)
					sense_d = '{ascq: 8'h00, asc: RBCD_ASC_BAD_FIELD, key: RBCD_SK_ILLEGAL, status: RBCD_ST_CHECK};
				else if (ctrl_q[RBCD_CTRL_WB_BLOCK])
					sense_d = '{ascq: 8'h00, asc: RBCD_ASC_SEQ_ERR, key: RBCD_SK_ILLEGAL, status: RBCD_ST_CHECK};
				else
					do_wb = 1'b1;
			end
			default: sense_d = '{ascq: 8'h00, asc: RBCD_ASC_BAD_OP, key: RBCD_SK_ILLEGAL, status: RBCD_ST_CHECK};
		endcase
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sense_q <= '0;
			last_q <= '0;
			data_q <= 32'h0000_0000;
		end else if (go_q) begin
			sense_q <= sense_d;
			data_q <= data_d;
			if (op != RBCD_OP_REQ_SENSE)
				last_q <= sense_d;
		end
	end
	// Mode page store: current and saved kept apart
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cur_q <= RBCD_MODE_DEF;
			saved_q <= RBCD_MODE_DEF;
			cur_valid_q <= 1'b0;
			saved_valid_q <= 1'b0;
		end else if (go_q) begin
			if (do_sel) begin
				cur_q <= sel_val;
				cur_valid_q <= 1'b1;
			end
			if (do_save) begin
				saved_q <= do_sel ? sel_val : cur_q;
				saved_valid_q <= 1'b1;
			end else if (do_restore) begin
				saved_q <= RBCD_MODE_DEF;
				saved_valid_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lock_q <= 1'b0;
			wbo_q <= 24'h0;
			wbl_q <= 24'h0;
		end else if (go_q) begin
			if (do_lock)
				lock_q <= cdb[32];
			if (do_wb) begin
				wbo_q <= wb_ofs;
				wbl_q <= wb_len;
			end
		end
	end
	// ----------------------------------------------------------------
	// Information exceptions
	// ----------------------------------------------------------------
	assign exc_ev = exc_event && exc_qual[7:4] >= RBCD_QX_MIN && exc_qual[7:4] <= RBCD_QX_MAX
		&& exc_qual[3:0] <= RBCD_QY_MAX;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			exc_pend_q <= 1'b0;
			exc_q <= 8'h00;
			aen_req <= 1'b0;
		end else begin
			if (exc_ev) begin
				exc_pend_q <= 1'b1;
				exc_q <= exc_qual;
			end else if (aen_done)
				exc_pend_q <= 1'b0;
			aen_req <= ctrl_q[RBCD_CTRL_AEN] & (exc_ev | (exc_pend_q & ~aen_done));
		end
	end
	// ----------------------------------------------------------------
	// Interrupts and read path
	// ----------------------------------------------------------------
	logic [2:0] istat_q, iev;
	assign iev = {go_q & (sense_d.status == RBCD_ST_CHECK), exc_ev, go_q};
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			istat_q <= 3'h0;
			irq <= 1'b0;
		end else begin
			istat_q <= (istat_q & ~{3{rd_fire && s_araddr == RBCD_IRQ_STAT}}) | iev;
			irq <= |(istat_q & imask_q);
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		case (s_araddr)
			RBCD_CDB0: rd_d = cdb0_q;
			RBCD_CDB1: rd_d = cdb1_q;
			RBCD_CDB2: rd_d = cdb2_q;
			RBCD_CTRL: rd_d = ctrl_q;
			RBCD_RESULT: rd_d = sense_q;
			RBCD_DATA: rd_d = data_q;
			RBCD_MODE_CUR: rd_d = cur_q;
			RBCD_MODE_SAVED: rd_d = saved_q;
			RBCD_MODE_PARAM: rd_d = param_q;
			RBCD_WB_OFFSET: rd_d = {8'h00, wbo_q};
			RBCD_WB_LENGTH: rd_d = {8'h00, wbl_q};
			RBCD_IRQ_STAT: rd_d = {29'h0, istat_q};
			RBCD_IRQ_MASK: rd_d = {29'h0, imask_q};
			RBCD_STATUS: rd_d = {27'h0, req_sense_need, rmb, exc_pend_q, saved_valid_q, lock_q};
			default: begin
				rd_d = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
		end else if (rd_fire) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rd_hit ? 2'h0 : 2'h2;
		end else begin
			if (s_rready)
				rvalid_q <= 1'b0;
			if (!rvalid_q)
				arready_q <= 1'b1;
		end
	end

	assign s_awready = awready_q;
	assign s_wready = wready_q;
	assign s_bvalid = bvalid_q;
	assign s_bresp = bresp_q;
	assign s_arready = arready_q;
	assign s_rvalid = rvalid_q;
	assign s_rdata = rdata_q;
	assign s_rresp = rresp_q;
	assign medium_locked = lock_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_vpd_serial: assert property (go_q && op == RBCD_OP_INQUIRY && cdb[8] && cdb[23:16] == 8'h80 |=>
		sense_q.status == 8'h00 && data_q == 32'h80) else $error("serial page not answered");
	a_vpd_devid: assert property (go_q && op == RBCD_OP_INQUIRY && cdb[8] && cdb[23:16] == 8'h83 |=>
		sense_q.status == 8'h00 && data_q == 32'h83) else $error("device id page not answered");
	a_sel_zero_len: assert property (go_q && op == RBCD_OP_MODE_SEL && cdb[39:32] == 8'h00 && !cdb[8] |=>
		sense_q.status == 8'h00 && $stable(cur_q)) else $error("zero length select misbehaved");
	a_sel_fixed_bits: assert property (go_q && op == RBCD_OP_MODE_SEL |=>
		(cur_q & ~RBCD_MODE_CHG) == ($past(cur_q) & ~RBCD_MODE_CHG)) else $error("fixed mode bits changed");
	a_sp_save: assert property (go_q && op == RBCD_OP_MODE_SEL && cdb[8] && !rmb |=>
		saved_q == cur_q && saved_valid_q) else $error("save pages not stored");
	a_sp_reject: assert property (go_q && op == RBCD_OP_MODE_SEL && cdb[8] && rmb && !save_ok |=>
		sense_q == 32'h0024_0502) else $error("save pages not rejected");
	a_sense_default: assert property (go_q && op == RBCD_OP_MODE_SENSE && cdb[23:22] == 2'h2 |=>
		data_q == RBCD_MODE_DEF) else $error("defaults not reported");
	a_tur_exception: assert property (go_q && op == RBCD_OP_TUR && exc_pend_q |=>
		sense_q.key == 8'h01 && sense_q.asc == 8'h5d && sense_q.ascq == $past(exc_q)) else $error("bad exception sense");
	a_exc_clear: assert property (aen_done && !exc_ev |=> !exc_pend_q && !aen_req)
		else $error("exception not cleared");
	a_wb_modes: assert property (go_q && op == RBCD_OP_WRITE_BUF && wb_mode[0] && wb_mode[2] &&
		!ctrl_q[RBCD_CTRL_WB_BLOCK] |=> sense_q.status == 8'h00 && wbl_q == $past(wb_len)) else $error("buffer write refused");
	a_prevent_rmb: assert property (go_q && op == RBCD_OP_PREVENT && rmb |=>
		sense_q.status == 8'h00 ##0 medium_locked == $past(cdb[32])) else $error("prevent not honoured");

	c_mode_save: cover property (go_q && op == RBCD_OP_MODE_SEL && cdb[8] ##[1:200] go_q);
	c_tur_exc: cover property (exc_ev ##[1:20] go_q && op == RBCD_OP_TUR);
	c_irq_raise: cover property (go_q ##2 irq);
endmodule // rbcd_top
`default_nettype wire

// >>> testbench/rbcd_init_model.sv
// Far-side model: threshold event source and notification receiver
`timescale 1ns/1ns
`default_nettype none
module rbcd_init_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Bench control
	input wire logic fire,
	input wire logic slow,
	input wire logic [7:0] qual,
	// Device side
	input wire logic aen_req,
	output logic exc_event,
	output logic [7:0] exc_qual,
	output logic aen_done
);
	logic [3:0] wait_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			exc_event <= 1'b0;
			exc_qual <= 8'h00;
			aen_done <= 1'b0;
			wait_q <= 4'h0;
		end else begin
			exc_event <= fire;
			// Qualifier carries no meaning outside the pulse
			exc_qual <= fire ? qual : ~exc_qual;
			aen_done <= 1'b0;
			if (aen_req && !aen_done) begin
				wait_q <= wait_q + 4'h1;
				if (wait_q == (slow ? 4'h7 : 4'h0)) begin
					aen_done <= 1'b1;
					wait_q <= 4'h0;
				end
			end
		end
	end
endmodule // rbcd_init_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the command interpreter
`timescale 1ns/1ns
`default_nettype none
module testbench import rbcd_pkg::*;;
	logic clk_sys, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, fire, slow;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, aen_req, medium_locked, irq, exc_event, aen_done;
	logic [7:0] s_awaddr, s_araddr, exc_qual, qual;
	logic [31:0] s_wdata, s_rdata, ctrl_bits, prm, mcur;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp;
	logic [23:0] ofs, len;
	logic [33:0] expq[$];
	int miscompares, comparisons, cyc, seed;
	localparam logic [31:0] R_OK = 32'h0000_0000;
	localparam logic [31:0] R_FIELD = {8'h00, RBCD_ASC_BAD_FIELD, RBCD_SK_ILLEGAL, RBCD_ST_CHECK};
	localparam logic [31:0] R_OP = {8'h00, RBCD_ASC_BAD_OP, RBCD_SK_ILLEGAL, RBCD_ST_CHECK};
	localparam logic [31:0] R_SEQ = {8'h00, RBCD_ASC_SEQ_ERR, RBCD_SK_ILLEGAL, RBCD_ST_CHECK};

	rbcd_top DUT (.clk_sys, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
		.s_rready, .exc_event, .exc_qual, .aen_done, .aen_req, .medium_locked, .irq);
	rbcd_init_model partner (.clk_sys, .rst, .fire, .slow, .qual, .aen_req, .exc_event, .exc_qual, .aen_done);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Register bus master
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_awready === 1'b1) s_awvalid <= 1'b0;
			if (s_wready === 1'b1) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
		chk("write response", 34'(s_bresp), 34'(rsp));
		s_bready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
		expq.push_back({rsp, d});
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_arready === 1'b1) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		s_rready <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Result watcher takes the oldest expectation per read
	always @(posedge clk_sys)
		if (s_rvalid === 1'b1 && s_rready === 1'b1) chk("read data", {s_rresp, s_rdata}, expq.pop_front());

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test;
		end
	end

	// Descriptor bytes 0..9 from the top of c, then go, then the result
	task automatic cmd(input logic [79:0] c, input logic [31:0] res);
		wr(RBCD_CDB0, {c[55:48], c[63:56], c[71:64], c[79:72]}, 2'h0);
		wr(RBCD_CDB1, {c[23:16], c[31:24], c[39:32], c[47:40]}, 2'h0);
		wr(RBCD_CDB2, {16'h0000, c[7:0], c[15:8]}, 2'h0);
		wr(RBCD_CTRL, ctrl_bits | 32'h0000_0001, 2'h0);
		repeat (3) @(posedge clk_sys);
		rd(RBCD_RESULT, res, 2'h0);
	endtask

	task automatic pulse(input logic [7:0] q);
		fire <= 1'b1;
		qual <= q;
		@(posedge clk_sys);
		fire <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	initial begin
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, fire, slow} = 7'h00;
		{s_awaddr, s_araddr, qual, s_wdata, ctrl_bits} = 88'h0;
		s_wstrb = 4'hf;
		seed = 92;
		rst = 1'b1;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(RBCD_CTRL, RBCD_CTRL_RST, 2'h0);
		rd(RBCD_IRQ_MASK, 32'h0000_0000, 2'h0);
		rd(RBCD_STATUS, 32'h0000_0010, 2'h0);
		rd(8'h3c, 32'h0000_0000, 2'h2);
		wr(8'h3c, 32'hffff_ffff, 2'h2);
		wr(RBCD_RESULT, 32'hffff_ffff, 2'h2);
		ctrl_bits = 32'h0000_0038;
		wr(RBCD_CTRL, ctrl_bits, 2'h0);
		rd(RBCD_STATUS, 32'h0000_0000, 2'h0);
		$display("Test registers done");
		cmd(80'h12_01_80_00_00_00_00_00_00_00, R_OK);
		cmd(80'h12_01_83_00_00_00_00_00_00_00, R_OK);
		cmd(80'h12_01_81_00_00_00_00_00_00_00, R_FIELD);
		$display("Test inquiry done");
		prm = $random(seed);
		wr(RBCD_MODE_PARAM, prm, 2'h0);
		s_wstrb <= 4'h1;
		wr(RBCD_MODE_PARAM, ~prm, 2'h0);
		s_wstrb <= 4'hf;
		prm = {prm[31:8], ~prm[7:0]};
		rd(RBCD_MODE_PARAM, prm, 2'h0);
		mcur = (RBCD_MODE_DEF & ~RBCD_MODE_CHG) | (prm & RBCD_MODE_CHG);
		cmd(80'h15_10_00_00_00_00_00_00_00_00, R_OK);
		for (int k = 0; k < 8; k++) begin
			if (k == 4) begin
				cmd(80'h15_11_00_00_04_00_00_00_00_00, R_OK);
				rd(RBCD_MODE_CUR, mcur, 2'h0);
				rd(RBCD_MODE_SAVED, mcur, 2'h0);
			end
			cmd({8'h1a, 8'h08, 2'(k), 6'h3f, 56'h0}, R_OK);
			rd(RBCD_DATA, k % 4 == 1 ? RBCD_MODE_CHG : (k % 4 == 2 || k < 4) ? RBCD_MODE_DEF : mcur, 2'h0);
		end
		$display("Test mode pages done");
		ctrl_bits[RBCD_CTRL_RMB] = 1'b1;
		cmd(80'h15_11_00_00_04_00_00_00_00_00, R_FIELD);
		cmd(80'h1e_00_00_00_01_00_00_00_00_00, R_OK);
		chk("medium_locked", 34'(medium_locked), 34'h1);
		cmd(80'h1e_00_00_00_00_00_00_00_00_00, R_OK);
		chk("medium_locked", 34'(medium_locked), 34'h0);
		ctrl_bits[RBCD_CTRL_RMB] = 1'b0;
		cmd(80'h1e_00_00_00_01_00_00_00_00_00, R_OP);
		$display("Test removal done");
		for (int m = 0; m < 8; m++) begin
			ofs = 24'($random(seed));
			len = 24'($random(seed));
			cmd({8'h3b, 5'h00, 3'(m), 8'h00, ofs, len, 8'h00}, (m == 5 || m == 7) ? R_OK : R_FIELD);
			if (m == 5 || m == 7) begin
				rd(RBCD_WB_OFFSET, {8'h00, ofs}, 2'h0);
				rd(RBCD_WB_LENGTH, {8'h00, len}, 2'h0);
			end
		end
		ctrl_bits[RBCD_CTRL_WB_BLOCK] = 1'b1;
		cmd({8'h3b, 8'h05, 64'h0}, R_SEQ);
		$display("Test buffer write done");
		rd(RBCD_IRQ_STAT, 32'h0000_0005, 2'h0);
		wr(RBCD_IRQ_MASK, 32'h0000_0002, 2'h0);
		ctrl_bits = 32'h0000_0028;
		pulse(8'h7d);
		chk("irq", 34'(irq), 34'h0);
		cmd(80'h00_00_00_00_00_00_00_00_00_00, R_OK);
		pulse(8'h3c);
		chk("irq", 34'(irq), 34'h1);
		pulse(8'h1d);
		cmd(80'h00_00_00_00_00_00_00_00_00_00, 32'h3c5d_0102);
		cmd(80'h03_00_00_00_12_00_00_00_00_00, R_OK);
		rd(RBCD_DATA, 32'h3c5d_0102, 2'h0);
		rd(RBCD_IRQ_STAT, 32'h0000_0007, 2'h0);
		slow <= 1'b1;
		ctrl_bits[RBCD_CTRL_AEN] = 1'b1;
		wr(RBCD_CTRL, ctrl_bits, 2'h0);
		chk("aen_req", 34'(aen_req), 34'h1);
		for (int i = 0; i < 40 && aen_req !== 1'b0; i++) @(posedge clk_sys);
		cmd(80'h00_00_00_00_00_00_00_00_00_00, R_OK);
		$display("Test exceptions done");
		stop_test;
	end
endmodule // testbench
`default_nettype wire
